// file: flash_cmd_defines.svh
// Constants for the flash command sequencer
// Functional notes
// [R1] Sector erase: code 0x0A, address in words 0/1
// [R2] Launch erases sector, verifies, then sets complete
// [R3] Sector erase needs word index 001
// [R4] Sector erase address must be phrase aligned
// [R5] Protected sector: protection flag, no erase
// [R6] Mode not allowed or bad address: access error
// [R7] Verify errors set verify flags
// [R8] Unsecure: code 0x0B, index 000, erase all
// [R9] Failed unsecure verify keeps security
// [R10] Any protection blocks unsecure
// [R11] Host writes nothing while unsecure runs
// [R12] Backdoor key: code 0x0C, index 100
// [R13] Backdoor enable must be binary 10
// [R14] Keys compared in order, all must match
// [R15] Mismatch locks backdoor until reset
// [R16] Margin: address words 0/1, level word 2, index 010
// [R17] Margin applied, no protection or verify flags
// [R18] Flash-block margin also applies to EEPROM
// [R19] Levels 0,1,2 valid, others access error
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH
`define FC_OFF_INDEX      8'h00
`define FC_OFF_STATUS     8'h04
`define FC_OFF_SECURITY   8'h08
`define FC_OFF_PROT       8'h0C
`define FC_OFF_CMD_EN     8'h10
`define FC_OFF_MARGIN     8'h14
`define FC_OFF_IRQ_STAT   8'h18
`define FC_OFF_IRQ_MASK   8'h1C
`define FC_OFF_PARAM0     8'h20
`define FC_OFF_PARAM4     8'h30
`define FC_ST_COMPLETE    7
`define FC_ST_ACC_ERR     5
`define FC_ST_PROT_ERR    4
`define FC_ST_MG1         1
`define FC_ST_MG0         0
`define FC_CMD_ERASE_SECT 8'h0A
`define FC_CMD_UNSECURE   8'h0B
`define FC_CMD_BACKDOOR   8'h0C
`define FC_CMD_MARGIN     8'h0D
`define FC_IDX_ERASE      3'h1
`define FC_IDX_UNSECURE   3'h0
`define FC_IDX_BACKDOOR   3'h4
`define FC_IDX_MARGIN     3'h2
`define FC_BACKDOOR_ON    2'h2
`define FC_SEC_UNSECURE   2'h2
`define FC_SEC_RESET      2'h3
`define FC_LVL_NORMAL     2'h0
`define FC_LVL_MAX        16'h0002
`define FC_PF_BASE_HI     8'hFF
`define FC_EE_BASE_HI     8'h10
`define FC_EE_TOP_LO      16'h07FF
`define FC_KEY_LAST       2'h3
`define FC_CMD_EN_RESET   4'hF
`define FC_PROT_RESET     9'h000
`endif

// file: flash_cmd_pkg.sv
// Types shared by the flash command sequencer
package flash_cmd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CHECK  = 3'h1,
		ST_ERASE  = 3'h3,
		ST_KEYCMP = 3'h2,
		ST_DONE   = 3'h6
	} state_type;
	typedef enum logic [1:0] {
		ACT_NONE   = 2'h0,
		ACT_ERASE  = 2'h1,
		ACT_KEY    = 2'h2,
		ACT_MARGIN = 2'h3
	} act_type;
endpackage : flash_cmd_pkg

// file: flash_erase_engine.sv
// Erase and blank-verify sequencing toward the flash array
`timescale 1ns/1ps
module flash_erase_engine #(
	parameter int SECTOR_CYCLES = 64,
	parameter int ALL_CYCLES    = 1024
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic        erase_all,
	input  wire logic [23:0] addr,
	input  wire logic        verify_err,
	input  wire logic        verify_uncorr,
	output logic             erase_en,
	output logic             erase_all_q,
	output logic [23:0]      erase_addr,
	output logic             done,
	output logic             err_q,
	output logic             uncorr_q
);
	logic [15:0] cnt_q;

	// Erase pulse, then verify result sampled at the last cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_en    <= 1'b0;
			erase_all_q <= 1'b0;
			erase_addr  <= 24'h000000;
			cnt_q       <= 16'h0000;
			done        <= 1'b0;
			err_q       <= 1'b0;
			uncorr_q    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !erase_en) begin
				erase_en    <= 1'b1;
				erase_all_q <= erase_all;
				erase_addr  <= addr;
				cnt_q       <= erase_all ? 16'(ALL_CYCLES - 1) : 16'(SECTOR_CYCLES - 1);
			end else if (erase_en) begin
				if (cnt_q == 16'h0000) begin
					erase_en <= 1'b0;
					done     <= 1'b1;
					err_q    <= verify_err | verify_uncorr;
					uncorr_q <= verify_uncorr;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end
endmodule : flash_erase_engine

// file: flash_cmd_seq.sv
// Flash command sequencer: sector erase, unsecure, backdoor key, user margin
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_cmd_seq #(
	parameter int SECTOR_CYCLES = 64,
	parameter int ALL_CYCLES    = 1024
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic [63:0] backdoor_key,
	input  wire logic        array_verify_err,
	input  wire logic        array_verify_uncorr,
	output logic             array_erase_en,
	output logic             array_erase_all,
	output logic [23:0]      array_erase_addr,
	output logic             secured,
	output logic [1:0]       pflash_margin,
	output logic [1:0]       eeprom_margin
);
	flash_cmd_pkg::state_type state_q;
	flash_cmd_pkg::act_type   chk_act;
	logic [2:0]  command_word_index;
	logic [15:0] command_parameter_words [0:4];
	logic        command_complete_flag;
	logic        access_error_flag;
	logic        protection_violation_flag;
	logic        verify_error_flag;
	logic        verify_uncorrectable_flag;
	logic [1:0]  sec_q;
	logic [1:0]  backdoor_enable_field;
	logic [8:0]  prot_q;
	logic [3:0]  cmd_en_q;
	logic        key_lock_q;
	logic [1:0]  key_ptr_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic        chk_acc;
	logic        chk_prot;
	logic        key_ok;
	logic        eng_done;
	logic        eng_err;
	logic        eng_uncorr;
	logic        acc_fire;
	logic        wr_fire;
	logic        launch;
	logic        busy;
	logic        known;
	logic [7:0]  cmd;
	logic [23:0] gaddr;
	logic [31:0] rd_d;
	logic [7:0]  flash_status_reg;

	function automatic logic is_pflash(input logic [23:0] a);
		is_pflash = (a[23:16] == `FC_PF_BASE_HI);
	endfunction : is_pflash

	function automatic logic is_eeprom(input logic [23:0] a);
		is_eeprom = (a[23:16] == `FC_EE_BASE_HI) && (a[15:0] <= `FC_EE_TOP_LO);
	endfunction : is_eeprom

	function automatic logic [15:0] key_word(input logic [63:0] k, input logic [1:0] p);
		key_word = k[{p, 4'h0} +: 16];
	endfunction : key_word

	function automatic logic w1c(input logic [31:0] d, input int b);
		w1c = d[b];
	endfunction : w1c

	assign acc_fire = psel && penable && pready;
	assign wr_fire  = acc_fire && pwrite;
	assign busy     = (state_q != flash_cmd_pkg::ST_IDLE);
	assign cmd      = command_parameter_words[0][15:8];
	assign gaddr    = {command_parameter_words[0][7:0], command_parameter_words[1]};
	assign flash_status_reg = {command_complete_flag, 1'b0, access_error_flag,
		protection_violation_flag, 2'b00, verify_error_flag, verify_uncorrectable_flag};

	// Launch by writing one to the complete flag; ignored while access or protection errors stand
	assign launch = wr_fire && (paddr == `FC_OFF_STATUS) && w1c(pwdata, `FC_ST_COMPLETE) &&
		command_complete_flag && !access_error_flag && !protection_violation_flag && !busy;

	assign key_ok = (command_parameter_words[3'({1'b0, key_ptr_q} + 3'h1)] ==
		key_word(backdoor_key, key_ptr_q)); // R14

	// Launch checks, evaluated in the check state
	always_comb begin
		chk_acc  = 1'b0;
		chk_prot = 1'b0;
		chk_act  = flash_cmd_pkg::ACT_NONE;
		case (cmd)
			`FC_CMD_ERASE_SECT: begin // R1
				if (command_word_index != `FC_IDX_ERASE) begin
					chk_acc = 1'b1; // R3
				end else if (!cmd_en_q[0] || !is_pflash(gaddr)) begin
					chk_acc = 1'b1; // R6
				end else if (gaddr[2:0] != 3'h0) begin
					chk_acc = 1'b1; // R4
				end else if (prot_q[gaddr[15:13]]) begin
					chk_prot = 1'b1; // R5
				end else begin
					chk_act = flash_cmd_pkg::ACT_ERASE; // R2
				end
			end
			`FC_CMD_UNSECURE: begin // R8
				if (command_word_index != `FC_IDX_UNSECURE || !cmd_en_q[1]) begin
					chk_acc = 1'b1; // R6
				end else if (prot_q != `FC_PROT_RESET) begin
					chk_prot = 1'b1; // R10
				end else begin
					chk_act = flash_cmd_pkg::ACT_ERASE;
				end
			end
			`FC_CMD_BACKDOOR: begin // R12
				if (command_word_index != `FC_IDX_BACKDOOR || !cmd_en_q[2]) begin
					chk_acc = 1'b1; // R6
				end else if (backdoor_enable_field != `FC_BACKDOOR_ON) begin
					chk_acc = 1'b1; // R13
				end else if (key_lock_q) begin
					chk_acc = 1'b1; // R15
				end else begin
					chk_act = flash_cmd_pkg::ACT_KEY;
				end
			end
			`FC_CMD_MARGIN: begin // R16
				if (command_word_index != `FC_IDX_MARGIN || !cmd_en_q[3]) begin
					chk_acc = 1'b1; // R6
				end else if (!is_pflash(gaddr) && !is_eeprom(gaddr)) begin
					chk_acc = 1'b1; // R6
				end else if (command_parameter_words[2] > `FC_LVL_MAX) begin
					chk_acc = 1'b1; // R19
				end else begin
					chk_act = flash_cmd_pkg::ACT_MARGIN; // R17
				end
			end
			default: begin
				chk_acc = 1'b1;
			end
		endcase
	end

	// Command state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= flash_cmd_pkg::ST_IDLE;
		end else begin
			case (state_q)
				flash_cmd_pkg::ST_IDLE: begin
					if (launch) begin
						state_q <= flash_cmd_pkg::ST_CHECK;
					end
				end
				flash_cmd_pkg::ST_CHECK: begin
					case (chk_act)
						flash_cmd_pkg::ACT_ERASE: state_q <= flash_cmd_pkg::ST_ERASE;
						flash_cmd_pkg::ACT_KEY:   state_q <= flash_cmd_pkg::ST_KEYCMP;
						default:                  state_q <= flash_cmd_pkg::ST_DONE;
					endcase
				end
				flash_cmd_pkg::ST_ERASE: begin
					if (eng_done) begin
						state_q <= flash_cmd_pkg::ST_DONE; // R2
					end
				end
				flash_cmd_pkg::ST_KEYCMP: begin
					if (!key_ok || key_ptr_q == `FC_KEY_LAST) begin
						state_q <= flash_cmd_pkg::ST_DONE;
					end
				end
				flash_cmd_pkg::ST_DONE: begin
					state_q <= flash_cmd_pkg::ST_IDLE;
				end
				default: begin
					state_q <= flash_cmd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Key pointer walks key 0..3 one per cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_ptr_q <= 2'h0;
		end else if (state_q == flash_cmd_pkg::ST_KEYCMP) begin
			key_ptr_q <= key_ptr_q + 2'h1; // R14
		end else begin
			key_ptr_q <= 2'h0;
		end
	end

	// Lockout after a mismatch, cleared only by reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_lock_q <= 1'b0;
		end else if (state_q == flash_cmd_pkg::ST_KEYCMP && !key_ok) begin
			key_lock_q <= 1'b1; // R15
		end
	end

	// Command complete flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			command_complete_flag <= 1'b1;
		end else if (launch) begin
			command_complete_flag <= 1'b0;
		end else if (state_q == flash_cmd_pkg::ST_DONE) begin
			command_complete_flag <= 1'b1; // R2
		end
	end

	// Error flags: hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_error_flag         <= 1'b0;
			protection_violation_flag <= 1'b0;
		end else begin
			if (wr_fire && paddr == `FC_OFF_STATUS) begin
				if (w1c(pwdata, `FC_ST_ACC_ERR)) begin
					access_error_flag <= 1'b0;
				end
				if (w1c(pwdata, `FC_ST_PROT_ERR)) begin
					protection_violation_flag <= 1'b0;
				end
			end
			if (state_q == flash_cmd_pkg::ST_CHECK && chk_acc) begin
				access_error_flag <= 1'b1; // R6
			end
			if (state_q == flash_cmd_pkg::ST_KEYCMP && !key_ok) begin
				access_error_flag <= 1'b1; // R15
			end
			if (state_q == flash_cmd_pkg::ST_CHECK && chk_prot) begin
				protection_violation_flag <= 1'b1; // R5 R10
			end
		end
	end

	// Verify flags cleared at launch, loaded at the end of erase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			verify_error_flag         <= 1'b0;
			verify_uncorrectable_flag <= 1'b0;
		end else if (launch) begin
			verify_error_flag         <= 1'b0;
			verify_uncorrectable_flag <= 1'b0;
		end else if (state_q == flash_cmd_pkg::ST_ERASE && eng_done) begin
			verify_error_flag         <= eng_err; // R7
			verify_uncorrectable_flag <= eng_uncorr; // R7
		end
	end

	// Security state; software writes only the backdoor enable field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_q                 <= `FC_SEC_RESET;
			backdoor_enable_field <= 2'h0;
		end else begin
			if (wr_fire && !busy && paddr == `FC_OFF_SECURITY) begin
				backdoor_enable_field <= pwdata[7:6];
			end
			if (state_q == flash_cmd_pkg::ST_ERASE && eng_done && !eng_err &&
				cmd == `FC_CMD_UNSECURE) begin
				sec_q <= `FC_SEC_UNSECURE; // R8 R9
			end
			if (state_q == flash_cmd_pkg::ST_KEYCMP && key_ok && key_ptr_q == `FC_KEY_LAST) begin
				sec_q <= `FC_SEC_UNSECURE; // R14
			end
		end
	end

	// Read margin levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pflash_margin <= `FC_LVL_NORMAL;
			eeprom_margin <= `FC_LVL_NORMAL;
		end else if (state_q == flash_cmd_pkg::ST_CHECK && chk_act == flash_cmd_pkg::ACT_MARGIN) begin
			eeprom_margin <= command_parameter_words[2][1:0]; // R18
			if (is_pflash(gaddr)) begin
				pflash_margin <= command_parameter_words[2][1:0]; // R18
			end
		end
	end

	// Software-written configuration; locked while a command runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			command_word_index <= 3'h0;
			prot_q             <= `FC_PROT_RESET;
			cmd_en_q           <= `FC_CMD_EN_RESET;
			irq_mask_q         <= 2'h0;
			for (int i = 0; i < 5; i++) begin
				command_parameter_words[i] <= 16'h0000;
			end
		end else if (wr_fire && !busy) begin // R11
			case (paddr)
				`FC_OFF_INDEX:    command_word_index <= pwdata[2:0];
				`FC_OFF_PROT:     prot_q             <= pwdata[8:0];
				`FC_OFF_CMD_EN:   cmd_en_q           <= pwdata[3:0];
				`FC_OFF_IRQ_MASK: irq_mask_q         <= pwdata[1:0];
				default: begin
					if (paddr >= `FC_OFF_PARAM0 && paddr <= `FC_OFF_PARAM4 &&
						paddr[1:0] == 2'h0) begin
						command_parameter_words[3'(paddr[4:2])] <= pwdata[15:0];
					end
				end
			endcase
		end
	end

	// Interrupt status: bit0 completion, bit1 error; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 2'h0;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (wr_fire && paddr == `FC_OFF_IRQ_STAT && w1c(pwdata, b)) begin
					irq_stat_q[b] <= 1'b0;
				end
			end
			if (state_q == flash_cmd_pkg::ST_DONE) begin
				irq_stat_q[0] <= 1'b1;
			end
			if ((state_q == flash_cmd_pkg::ST_CHECK && (chk_acc || chk_prot)) ||
				(state_q == flash_cmd_pkg::ST_KEYCMP && !key_ok) ||
				(state_q == flash_cmd_pkg::ST_ERASE && eng_done && eng_err)) begin
				irq_stat_q[1] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq     <= 1'b0;
			secured <= 1'b1;
		end else begin
			irq     <= |(irq_stat_q & irq_mask_q);
			secured <= (sec_q != `FC_SEC_UNSECURE);
		end
	end

	// Read mux and address decode
	always_comb begin
		rd_d  = 32'h00000000;
		known = 1'b1;
		case (paddr)
			`FC_OFF_INDEX:    rd_d = {29'h0, command_word_index};
			`FC_OFF_STATUS:   rd_d = {24'h0, flash_status_reg};
			`FC_OFF_SECURITY: rd_d = {24'h0, backdoor_enable_field, 4'h0, sec_q};
			`FC_OFF_PROT:     rd_d = {23'h0, prot_q};
			`FC_OFF_CMD_EN:   rd_d = {28'h0, cmd_en_q};
			`FC_OFF_MARGIN:   rd_d = {28'h0, eeprom_margin, pflash_margin};
			`FC_OFF_IRQ_STAT: rd_d = {30'h0, irq_stat_q};
			`FC_OFF_IRQ_MASK: rd_d = {30'h0, irq_mask_q};
			default: begin
				if (paddr >= `FC_OFF_PARAM0 && paddr <= `FC_OFF_PARAM4 && paddr[1:0] == 2'h0) begin
					rd_d = {16'h0, command_parameter_words[3'(paddr[4:2])]};
				end else begin
					known = 1'b0;
				end
			end
		endcase
	end

	// APB slave: one wait state, answer registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !known;
			prdata  <= pwrite ? 32'h00000000 : rd_d;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	flash_erase_engine #(
		.SECTOR_CYCLES (SECTOR_CYCLES),
		.ALL_CYCLES    (ALL_CYCLES)
	) u_erase (
		.pclk          (pclk),
		.presetn       (presetn),
		.start         (state_q == flash_cmd_pkg::ST_CHECK && chk_act == flash_cmd_pkg::ACT_ERASE),
		.erase_all     (cmd == `FC_CMD_UNSECURE),
		.addr          (gaddr),
		.verify_err    (array_verify_err),
		.verify_uncorr (array_verify_uncorr),
		.erase_en      (array_erase_en),
		.erase_all_q   (array_erase_all),
		.erase_addr    (array_erase_addr),
		.done          (eng_done),
		.err_q         (eng_err),
		.uncorr_q      (eng_uncorr)
	);
endmodule : flash_cmd_seq

// file: flash_cmd_seq_properties.sv
// Port-level assertions for the flash command sequencer
`timescale 1ns/1ps
module flash_cmd_seq_properties #(
	parameter int SECTOR_CYCLES = 64,
	parameter int ALL_CYCLES    = 1024
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        array_verify_err,
	input wire logic        array_verify_uncorr,
	input wire logic        array_erase_en,
	input wire logic        array_erase_all,
	input wire logic [23:0] array_erase_addr,
	input wire logic        secured,
	input wire logic [1:0]  pflash_margin,
	input wire logic [1:0]  eeprom_margin
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// One wait state after setup
	sequence apb_wait;
		!pready ##1 pready;
	endsequence
	// Erase lasts a few cycles, then ends in bounded time
	sequence erase_run;
		array_erase_en [*3] ##[1:12] !array_erase_en;
	endsequence
	// Cycles the erase strobe has stood so far
	logic [15:0] run_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 16'h0000;
		end else if (array_erase_en) begin
			run_q <= run_q + 16'h0001;
		end else begin
			run_q <= 16'h0000;
		end
	end
	chk_erase_len: assert property ($fell(array_erase_en) |->
		run_q == (array_erase_all ? 16'(ALL_CYCLES) : 16'(SECTOR_CYCLES)))
		else $error("erase length differs from setting");
	chk_apb_wait: assert property (psel && !penable |=> apb_wait)
		else $error("pready not in second access cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_erase_run: assert property ($rose(array_erase_en) |-> erase_run)
		else $error("erase pulse length wrong");
	chk_sector_addr: assert property (array_erase_en && !array_erase_all |->
		array_erase_addr[23:16] == 8'hFF && array_erase_addr[2:0] == 3'h0)
		else $error("sector erase of bad address");
	chk_erase_stable: assert property (array_erase_en && $past(array_erase_en) |->
		$stable(array_erase_addr) && $stable(array_erase_all))
		else $error("erase target moved");
	chk_fail_keeps_sec: assert property ($fell(array_erase_en) &&
		$past(array_verify_err || array_verify_uncorr) |-> $stable(secured) [*4])
		else $error("security changed after failed verify");
	chk_level_legal: assert property (pflash_margin != 2'h3 && eeprom_margin != 2'h3)
		else $error("illegal margin level");
	chk_pf_both: assert property ($changed(pflash_margin) |-> eeprom_margin == pflash_margin)
		else $error("flash margin not applied to eeprom");
	chk_margin_quiet: assert property ($changed(pflash_margin) || $changed(eeprom_margin) |->
		!array_erase_en && $stable(secured))
		else $error("margin change with side effect");
endmodule : flash_cmd_seq_properties

bind flash_cmd_seq flash_cmd_seq_properties #(
	.SECTOR_CYCLES(SECTOR_CYCLES), .ALL_CYCLES(ALL_CYCLES)
) chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .array_verify_err(array_verify_err),
	.array_verify_uncorr(array_verify_uncorr), .array_erase_en(array_erase_en),
	.array_erase_all(array_erase_all), .array_erase_addr(array_erase_addr),
	.secured(secured), .pflash_margin(pflash_margin), .eeprom_margin(eeprom_margin)
);

// file: flash_cmd_seq_tb_top.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module flash_cmd_seq_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [63:0] bk = 64'h0;
	logic        verr = 1'b0;
	logic        uerr = 1'b0;
	logic [31:0] prdata, rd, r;
	logic        pready, pslverr, irq, er, ers, ersall, secured, a, seen_en, seen_all;
	logic [23:0] ersa, seen_a;
	logic [1:0]  pmo, emo, pm, em, tg, lv;
	logic [2:0]  ix;
	logic [7:0]  hi;
	logic [15:0] lo;
	logic [8:0]  pr;
	logic [3:0]  en;
	logic [31:0] seed = 32'hE5A8;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cyc = 0;

	flash_cmd_seq #(.SECTOR_CYCLES(4), .ALL_CYCLES(8)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .backdoor_key(bk), .array_verify_err(verr), .array_verify_uncorr(uerr),
		.array_erase_en(ers), .array_erase_all(ersall), .array_erase_addr(ersa),
		.secured(secured), .pflash_margin(pmo), .eeprom_margin(emo)
	);

	always #12.5 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc++;
		if (ers === 1'b1) begin
			seen_en = 1'b1;
			seen_all = ersall;
			seen_a = ersa;
		end
		if (cyc == 20000) begin
			$display("MISMATCH t=%0t run timed out", $time);
			fail_count++;
			finish_test();
		end
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Expected status byte: complete, access, protection, verify flags
	function automatic logic [31:0] est(input logic [1:0] af, input logic ok, input logic [1:0] vu);
		return {24'h0, 2'b10, af[1], af[0] & ~af[1], 2'b00, (vu[1] | vu[0]) & ok, vu[0] & ok};
	endfunction : est

	task check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
		end
	endtask : check

	task finish_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	task rst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask : rst

	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Load words, launch, poll completion, check flags and erase activity
	task automatic go(input logic [2:0] x, input logic [79:0] p, input logic [1:0] vu, af, e);
		logic ok;
		ok = e != 2'h0 && af == 2'h0;
		@(posedge pclk);
		verr <= vu[1];
		uerr <= vu[0];
		seen_en = 1'b0;
		apb(1'b1, 8'h00, {29'h0, x});
		for (int i = 0; i < 5; i++) apb(1'b1, 8'h20 + 8'(4 * i), {16'h0, p[16 * i +: 16]});
		apb(1'b1, 8'h04, 32'h80);
		do apb(1'b0, 8'h04, 32'h0); while (rd[7] !== 1'b1);
		check(rd & 32'hB3, est(af, ok, vu));
		check(seen_en, ok);
		if (ok) check(seen_all, e[1]);
		if (ok && e == 2'h1) check(seen_a, {p[7:0], p[31:16]});
		apb(1'b1, 8'h04, 32'h30);
	endtask : go

	initial begin
		bk <= {rnd(), rnd()};
		rst();
		apb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h3);
		apb(1'b0, 8'h10, 32'h0);
		check(rd, 32'hF);
		apb(1'b0, 8'h34, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
		check(secured, 1'b1);
		$display("test reset values done");
		for (int k = 0; k < 24; k++) begin
			r = rnd();
			ix = (r[2:0] != 3'h0) ? 3'h1 : r[5:3];
			hi = (r[7:6] != 2'h0) ? 8'hFF : r[15:8];
			lo = r[8] ? r[31:16] : {r[31:19], 3'h0};
			pr = (r[10:9] == 2'h0) ? r[18:10] : 9'h0;
			en = (r[12:11] == 2'h0) ? 4'hE : 4'hF;
			apb(1'b1, 8'h0C, {23'h0, pr});
			apb(1'b1, 8'h10, {28'h0, en});
			a = ix != 3'h1 || hi != 8'hFF || lo[2:0] != 3'h0 || !en[0];
			go(ix, {48'h0, lo, 8'h0A, hi}, r[14:13], {a, pr[lo[15:13]]}, 2'h1);
		end
		apb(1'b1, 8'h0C, 32'h0);
		apb(1'b1, 8'h10, 32'hF);
		$display("test sector erase done");
		pm = 2'h0;
		em = 2'h0;
		for (int k = 0; k < 16; k++) begin
			r = rnd();
			tg = k[3:2];
			lv = k[1:0];
			hi = (tg == 2'h1) ? 8'h10 : (tg == 2'h2) ? 8'h20 : 8'hFF;
			lo = (tg == 2'h1) ? {5'h0, r[10:0]} : r[15:0];
			a = tg[1] || lv == 2'h3;
			if (!a) em = lv;
			if (!a && tg == 2'h0) pm = lv;
			apb(1'b1, 8'h1C, {31'h0, k != 15});
			go((tg == 2'h3) ? 3'h3 : 3'h2, {32'h0, 14'h0, lv, lo, 8'h0D, hi}, 2'h0, {a, 1'b0}, 2'h0);
			check({emo, pmo}, {em, pm});
			apb(1'b0, 8'h14, 32'h0);
			check(rd, {28'h0, em, pm});
			check(irq, k != 15);
			apb(1'b1, 8'h18, 32'h3);
			repeat (2) @(negedge pclk);
			check(irq, 1'b0);
		end
		$display("test margin and interrupt done");
		apb(1'b1, 8'h08, 32'h40);
		go(3'h4, {bk, 16'h0C00}, 2'h0, 2'h2, 2'h0);
		apb(1'b1, 8'h08, 32'h80);
		go(3'h3, {bk, 16'h0C00}, 2'h0, 2'h2, 2'h0);
		go(3'h4, {bk ^ (64'h1 << r[5:0]), 16'h0C00}, 2'h0, 2'h2, 2'h0);
		check(secured, 1'b1);
		go(3'h4, {bk, 16'h0C00}, 2'h0, 2'h2, 2'h0);
		rst();
		apb(1'b1, 8'h08, 32'h80);
		go(3'h4, {bk, 16'h0C00}, 2'h0, 2'h0, 2'h0);
		check(secured, 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h82);
		$display("test backdoor key done");
		rst();
		apb(1'b1, 8'h0C, 32'h100);
		go(3'h0, 80'hB00, 2'h0, 2'h1, 2'h2);
		apb(1'b1, 8'h0C, 32'h0);
		go(3'h1, 80'hB00, 2'h0, 2'h2, 2'h2);
		apb(1'b1, 8'h10, 32'h0);
		go(3'h2, 80'h0DFF, 2'h0, 2'h2, 2'h0);
		go(3'h0, 80'hB00, 2'h0, 2'h2, 2'h2);
		apb(1'b1, 8'h10, 32'hF);
		go(3'h0, 80'h0E00, 2'h0, 2'h2, 2'h0);
		go(3'h0, 80'hB00, 2'h2, 2'h0, 2'h2);
		go(3'h0, 80'hB00, 2'h1, 2'h0, 2'h2);
		check(secured, 1'b1);
		go(3'h0, 80'hB00, 2'h0, 2'h0, 2'h2);
		check(secured, 1'b0);
		$display("test unsecure done");
		finish_test();
	end
endmodule : flash_cmd_seq_tb_top
